// ==== include/gpcn_defs.vh ====
`ifndef GPCN_DEFS_VH
`define GPCN_DEFS_VH

// Port width and reset values.
`define GPCN_WIDTH 16
`define GPCN_ANALOG_RST 16'hffff
`define GPCN_DIR_RST 16'hffff
`define GPCN_ZERO_RST 16'h0000

// Pins without change detection: port A bits 7 through 10.
`define GPCN_CN_CAPABLE 16'hf87f

// Register write operation codes.
`define GPCN_OP_BASE 2'h0
`define GPCN_OP_SET 2'h1
`define GPCN_OP_CLR 2'h2
`define GPCN_OP_INV 2'h3

// Register select codes.
`define GPCN_SEL_ANALOG 3'h0
`define GPCN_SEL_DIR 3'h1
`define GPCN_SEL_LATCH 3'h2
`define GPCN_SEL_ODC 3'h3
`define GPCN_SEL_CNEN 3'h4
`define GPCN_SEL_PU 3'h5
`define GPCN_SEL_PD 3'h6
`define GPCN_SEL_PORT 3'h7

// Remap output selection width and the null selection.
`define GPCN_RMP_W 4
`define GPCN_RMP_NULL 4'h0

`endif

// ==== rtl/gpcn_sync2.v ====
`timescale 1ns/1ps
`include "gpcn_defs.vh"

// ***************************************************************
// Two flip-flop synchroniser for a vector of pin levels.
// ***************************************************************
module gpcn_sync2 #(
   parameter WIDTH = 16
) (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire [WIDTH-1:0] i_async,
   output wire [WIDTH-1:0] o_sync
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_reg <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
      end
   end

   assign o_sync = sync_reg;
endmodule

// ==== rtl/gpcn_bitop.v ====
`timescale 1ns/1ps
`include "gpcn_defs.vh"

// ***************************************************************
// Base, set, clear and invert update of one control register.
// ***************************************************************
module gpcn_bitop #(
   parameter WIDTH = 16
) (
   input wire [WIDTH-1:0] i_cur,
   input wire [WIDTH-1:0] i_wdata,
   input wire [1:0] i_op,
   output reg [WIDTH-1:0] o_next
);
   always @* begin
      case (i_op)
         `GPCN_OP_BASE: o_next = i_wdata;
         `GPCN_OP_SET: o_next = i_cur | i_wdata;
         `GPCN_OP_CLR: o_next = i_cur & ~i_wdata;
         `GPCN_OP_INV: o_next = i_cur ^ i_wdata;
         default: o_next = i_cur;
      endcase
   end
endmodule

// ==== rtl/gpcn_port.v ====
`timescale 1ns/1ps
`include "gpcn_defs.vh"

//
// Functional notes
// R1 - Analog input use needs analog_select and direction both set by software.
// R2 - Digital peripherals see and drive a pin only while analog_select is clear.
// R3 - analog_select resets to all ones, so shared pins start analog.
// R4 - An output pin in analog mode still drives its latched level.
// R5 - pin_level reads return zero for pins configured as analog inputs.
// R6 - Software leaves one cycle between port writes and reading that port.
// R7 - An enabled input pin change raises the change interrupt request.
// R8 - Enabled pin changes are caught without a clock and request a wake.
// R9 - Port A bits seven to ten have no change detection.
// R10 - Per-pin change_irq_enable gates each pin's change interrupt.
// R11 - change_status shows a change since the last pin_level read.
// R12 - Independent per-pin pull-up and pull-down enables activate weak pulls.
// R13 - Software should disable pulls on change pins used as digital outputs.
// R14 - Set, clear and invert writes modify only bits written as one.
// R15 - Alias reads are undefined; results are seen through the base register.
// R16 - A remappable peripheral reaches a pin only when software maps it.
// R17 - A fixed peripheral drives and senses its default pin when active.
// R18 - An active remapped output overrides GPIO and other digital functions.
// R19 - Analog function always wins over a remapped peripheral.
// R20 - Direction one means input; all pins reset as inputs.
// R21 - Latch reads give the latch; pin_level reads give pins; writes hit latch.
// R22 - open_drain_control makes the pin pull low only and release high.
// R23 - Remap output selection zero, the reset value, connects no peripheral.
// R24 - Change compares synced level with last read value; irq ORs enabled status.
// R25 - Digital inputs pass a two-flop synchroniser before use.
//
module gpcn_port #(
   parameter WIDTH = `GPCN_WIDTH,
   parameter [WIDTH-1:0] CN_CAPABLE = `GPCN_CN_CAPABLE,
   parameter NPERIPH = 8
) (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_wr_en,
   input wire [2:0] i_wr_sel,
   input wire [1:0] i_wr_op,
   input wire [WIDTH-1:0] i_wr_data,
   input wire i_rd_en,
   input wire [2:0] i_rd_sel,
   input wire [1:0] i_rd_op,
   input wire [WIDTH-1:0] i_pin_in,
   input wire [WIDTH*`GPCN_RMP_W-1:0] i_remap_sel,
   input wire [NPERIPH-1:0] i_remap_out,
   input wire [NPERIPH-1:0] i_remap_oe,
   input wire [WIDTH-1:0] i_fixed_en,
   input wire [WIDTH-1:0] i_fixed_out,
   input wire [WIDTH-1:0] i_fixed_oe,
   output reg [WIDTH-1:0] o_rd_data,
   output reg [WIDTH-1:0] o_pin_out,
   output reg [WIDTH-1:0] o_pin_oe_n,
   output reg [WIDTH-1:0] o_pull_up,
   output reg [WIDTH-1:0] o_pull_down,
   output reg [WIDTH-1:0] o_analog_en,
   output reg [WIDTH-1:0] o_periph_in,
   output reg [WIDTH-1:0] o_fixed_in,
   output reg [WIDTH-1:0] o_change_status,
   output reg o_change_irq,
   output reg o_wake_req
);

   // ***************************************************************
   // Control registers.
   // ***************************************************************
   reg [WIDTH-1:0] analog_select_reg;
   reg [WIDTH-1:0] direction_reg;
   reg [WIDTH-1:0] output_latch_reg;
   reg [WIDTH-1:0] open_drain_control_reg;
   reg [WIDTH-1:0] change_irq_enable_reg;
   reg [WIDTH-1:0] pull_up_enable_reg;
   reg [WIDTH-1:0] pull_down_enable_reg;
   reg [WIDTH-1:0] last_read_reg;
   reg [WIDTH-1:0] change_status_reg;
   reg wake_clr_reg;

   wire [WIDTH-1:0] analog_next;
   wire [WIDTH-1:0] dir_next;
   wire [WIDTH-1:0] latch_next;
   wire [WIDTH-1:0] odc_next;
   wire [WIDTH-1:0] cnen_next;
   wire [WIDTH-1:0] pu_next;
   wire [WIDTH-1:0] pd_next;
   wire [WIDTH-1:0] pin_sync;
   wire [WIDTH-1:0] wake_sync;
   wire [WIDTH-1:0] cn_enabled;
   wire [WIDTH-1:0] pin_level;
   wire [WIDTH-1:0] change_detect;
   wire [WIDTH-1:0] change_status_next;
   wire port_read;
   wire latch_write;
   wire wr_analog;
   wire wr_dir;
   wire wr_odc;
   wire wr_cnen;
   wire wr_pu;
   wire wr_pd;
   wire [WIDTH-1:0] async_flag;
   wire [WIDTH-1:0] cmp_ref;

   // Each of the seven writable control registers has its own alias update instance. [R14]
   gpcn_bitop #(.WIDTH(WIDTH)) u_op_analog (
      .i_cur(analog_select_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(analog_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_dir (
      .i_cur(direction_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(dir_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_latch (
      .i_cur(output_latch_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(latch_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_odc (
      .i_cur(open_drain_control_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(odc_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_cnen (
      .i_cur(change_irq_enable_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(cnen_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_pu (
      .i_cur(pull_up_enable_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(pu_next)
   );

   gpcn_bitop #(.WIDTH(WIDTH)) u_op_pd (
      .i_cur(pull_down_enable_reg),
      .i_wdata(i_wr_data),
      .i_op(i_wr_op),
      .o_next(pd_next)
   );

   // ***************************************************************
   // Write decode.
   // ***************************************************************
   // Writes to the pin_level address land in the latch. [R21]
   assign latch_write = i_wr_en &&
      ((i_wr_sel == `GPCN_SEL_LATCH) || (i_wr_sel == `GPCN_SEL_PORT));
   assign wr_analog = i_wr_en && (i_wr_sel == `GPCN_SEL_ANALOG);
   assign wr_dir = i_wr_en && (i_wr_sel == `GPCN_SEL_DIR);
   assign wr_odc = i_wr_en && (i_wr_sel == `GPCN_SEL_ODC);
   assign wr_cnen = i_wr_en && (i_wr_sel == `GPCN_SEL_CNEN);
   assign wr_pu = i_wr_en && (i_wr_sel == `GPCN_SEL_PU);
   assign wr_pd = i_wr_en && (i_wr_sel == `GPCN_SEL_PD);

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         analog_select_reg <= `GPCN_ANALOG_RST; // [R3]
         direction_reg <= `GPCN_DIR_RST; // [R20]
         output_latch_reg <= `GPCN_ZERO_RST;
         open_drain_control_reg <= `GPCN_ZERO_RST;
         change_irq_enable_reg <= `GPCN_ZERO_RST;
         pull_up_enable_reg <= `GPCN_ZERO_RST;
         pull_down_enable_reg <= `GPCN_ZERO_RST;
      end else begin
         if (wr_analog) begin
            analog_select_reg <= analog_next;
         end
         if (wr_dir) begin
            direction_reg <= dir_next;
         end
         if (latch_write) begin
            output_latch_reg <= latch_next; // [R21]
         end
         if (wr_odc) begin
            open_drain_control_reg <= odc_next;
         end
         if (wr_cnen) begin
            change_irq_enable_reg <= cnen_next & CN_CAPABLE; // [R9]
         end
         if (wr_pu) begin
            pull_up_enable_reg <= pu_next;
         end
         if (wr_pd) begin
            pull_down_enable_reg <= pd_next;
         end
      end
   end

   // ***************************************************************
   // Input synchronisation and change detection.
   // ***************************************************************
   gpcn_sync2 #(.WIDTH(WIDTH)) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async(i_pin_in),
      .o_sync(pin_sync)
   ); // [R25]

   // Clockless capture: any departure of a pin from the level taken at the
   // last pin_level read sets a flag with no clock running.
   // The flag clears only from reset or a registered read pulse, never from the pin
   // itself, so set and clear cannot race on one pin edge.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_async
         reg flag_reg;
         wire diff_clk;
         wire clr_n;
         assign diff_clk = i_pin_in[g] ^ last_read_reg[g];
         assign clr_n = i_resetn && !wake_clr_reg;
         always @(posedge diff_clk or negedge clr_n) begin
            if (!clr_n) begin
               flag_reg <= 1'b0;
            end else begin
               flag_reg <= 1'b1; // [R8]
            end
         end
         assign async_flag[g] = flag_reg;
      end
   endgenerate

   gpcn_sync2 #(.WIDTH(WIDTH)) u_wake_sync (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_async(async_flag),
      .o_sync(wake_sync)
   );

   // ***************************************************************
   // Change status and interrupt.
   // ***************************************************************
   assign cn_enabled = change_irq_enable_reg & CN_CAPABLE; // [R9] [R10]
   assign pin_level = pin_sync & ~analog_select_reg; // [R5]
   assign port_read = i_rd_en && (i_rd_sel == `GPCN_SEL_PORT) &&
      (i_rd_op == `GPCN_OP_BASE);
   assign cmp_ref = port_read ? pin_sync : last_read_reg;
   assign change_detect = cn_enabled & (pin_sync ^ cmp_ref); // [R24]
   // A read takes the present level as reference, so its clear loses no change. [R11]
   // Status of a pin whose enable is cleared drops with it. [R10]
   assign change_status_next = (change_detect |
      (port_read ? {WIDTH{1'b0}} : change_status_reg)) & cn_enabled;

   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         last_read_reg <= `GPCN_ZERO_RST;
         change_status_reg <= `GPCN_ZERO_RST;
         wake_clr_reg <= 1'b0;
      end else begin
         if (port_read) begin
            last_read_reg <= pin_sync; // [R11]
         end
         change_status_reg <= change_status_next;
         // Pulse that clears the clockless change flags after a read.
         wake_clr_reg <= port_read; // [R8]
      end
   end

   // ***************************************************************
   // Pin drive with remap priority.
   // ***************************************************************
   reg [WIDTH-1:0] drv_val;
   reg [WIDTH-1:0] drv_en;
   reg [`GPCN_RMP_W-1:0] sel;
   integer i;

   always @* begin
      drv_val = {WIDTH{1'b0}};
      drv_en = {WIDTH{1'b0}};
      sel = `GPCN_RMP_NULL;
      for (i = 0; i < WIDTH; i = i + 1) begin
         sel = i_remap_sel[i*`GPCN_RMP_W +: `GPCN_RMP_W];
         if (!analog_select_reg[i] && sel != `GPCN_RMP_NULL &&
               sel <= NPERIPH && i_remap_oe[sel-1]) begin
            // Remapped output wins over all digital users. [R16] [R18] [R23]
            drv_val[i] = i_remap_out[sel-1];
            drv_en[i] = 1'b1;
         end else if (!analog_select_reg[i] && i_fixed_en[i]) begin
            drv_val[i] = i_fixed_out[i]; // [R17] [R2]
            drv_en[i] = i_fixed_oe[i];
         end else begin
            // Analog pins keep only the latch drive. [R19] [R4]
            drv_val[i] = output_latch_reg[i];
            drv_en[i] = !direction_reg[i]; // [R20]
         end
      end
   end

   // ***************************************************************
   // Registered outputs.
   // ***************************************************************
   always @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rd_data <= `GPCN_ZERO_RST;
         o_pin_out <= `GPCN_ZERO_RST;
         o_pin_oe_n <= {WIDTH{1'b1}};
         o_pull_up <= `GPCN_ZERO_RST;
         o_pull_down <= `GPCN_ZERO_RST;
         o_analog_en <= `GPCN_ANALOG_RST;
         o_periph_in <= `GPCN_ZERO_RST;
         o_fixed_in <= `GPCN_ZERO_RST;
         o_change_status <= `GPCN_ZERO_RST;
         o_change_irq <= 1'b0;
         o_wake_req <= 1'b0;
      end else begin
         // Open drain drives low only and releases for a high. [R22]
         o_pin_out <= drv_val & ~open_drain_control_reg;
         o_pin_oe_n <= ~(drv_en & ~(open_drain_control_reg & drv_val));
         o_pull_up <= pull_up_enable_reg; // [R12]
         o_pull_down <= pull_down_enable_reg; // [R12]
         o_analog_en <= analog_select_reg;
         o_periph_in <= pin_level; // [R2] [R25]
         o_fixed_in <= pin_level & i_fixed_en; // [R17]
         o_change_status <= change_status_reg;
         o_change_irq <= |change_status_reg; // [R7] [R24]
         o_wake_req <= |(wake_sync & cn_enabled); // [R8]
         if (i_rd_en && i_rd_op != `GPCN_OP_BASE) begin
            o_rd_data <= `GPCN_ZERO_RST; // [R15]
         end else if (i_rd_en) begin
            case (i_rd_sel)
               `GPCN_SEL_ANALOG: o_rd_data <= analog_select_reg;
               `GPCN_SEL_DIR: o_rd_data <= direction_reg;
               `GPCN_SEL_LATCH: o_rd_data <= output_latch_reg; // [R21]
               `GPCN_SEL_ODC: o_rd_data <= open_drain_control_reg;
               `GPCN_SEL_CNEN: o_rd_data <= change_irq_enable_reg;
               `GPCN_SEL_PU: o_rd_data <= pull_up_enable_reg;
               `GPCN_SEL_PD: o_rd_data <= pull_down_enable_reg;
               `GPCN_SEL_PORT: o_rd_data <= pin_level; // [R5] [R21]
               default: o_rd_data <= `GPCN_ZERO_RST;
            endcase
         end
      end
   end
endmodule

// ==== verif/gpcn_port_sva.sv ====
`timescale 1ns/1ps
// ******************************************
// Checker on the port outputs.
// ******************************************
module gpcn_port_sva (
   input wire i_ref_clk,
   input wire i_resetn,
   input wire i_rd_en,
   input wire [2:0] i_rd_sel,
   input wire [1:0] i_rd_op,
   input wire [63:0] i_remap_sel,
   input wire [7:0] i_remap_out,
   input wire [7:0] i_remap_oe,
   input wire [15:0] o_rd_data,
   input wire [15:0] o_pin_out,
   input wire [15:0] o_pin_oe_n,
   input wire [15:0] o_analog_en,
   input wire [15:0] o_periph_in,
   input wire [15:0] o_change_status,
   input wire o_change_irq
);
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_resetn);
   chk_analog_reset: assert property ($rose(i_resetn) |-> o_analog_en == 16'hffff)
      else $error("analog select not all ones after reset");
   chk_input_reset: assert property ($rose(i_resetn) |-> o_pin_oe_n == 16'hffff)
      else $error("pins not inputs after reset");
   chk_analog_reads: assert property (i_rd_en && i_rd_sel == 3'h7 && i_rd_op == 2'h0
      |=> (o_rd_data & o_analog_en) == 16'h0000)
      else $error("analog pin read as one");
   chk_alias_reads: assert property (i_rd_en && i_rd_op != 2'h0 |=> o_rd_data == 16'h0000)
      else $error("alias read not zero");
   chk_no_change: assert property ((o_change_status & 16'h0780) == 16'h0000)
      else $error("change status on incapable pin");
   chk_irq_or: assert property (o_change_irq == (o_change_status != 16'h0000))
      else $error("change irq not or of status");
   chk_periph_analog: assert property ((o_periph_in & o_analog_en) == 16'h0000)
      else $error("digital input seen on analog pin");
   chk_remap_wins: assert property (!o_analog_en[0] &&
      $past(i_remap_sel[3:0] == 4'h1 && i_remap_oe[0])
      |-> o_pin_out[0] == $past(i_remap_out[0]) && !o_pin_oe_n[0])
      else $error("remapped output not on pin");
endmodule

bind gpcn_port gpcn_port_sva chk_u (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
   .i_rd_en(i_rd_en), .i_rd_sel(i_rd_sel), .i_rd_op(i_rd_op), .i_remap_sel(i_remap_sel),
   .i_remap_out(i_remap_out), .i_remap_oe(i_remap_oe), .o_rd_data(o_rd_data),
   .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n), .o_analog_en(o_analog_en),
   .o_periph_in(o_periph_in), .o_change_status(o_change_status), .o_change_irq(o_change_irq));

// ==== verif/gpcn_pins_model.sv ====
`timescale 1ns/1ps
// ******************************************
// Pin wires with weak pulls and outside drivers.
// ******************************************
module gpcn_pins_model (
   input wire i_ref_clk,
   input wire [15:0] i_drive,
   input wire [15:0] i_drive_oe_n,
   input wire [15:0] i_pull_up,
   input wire [15:0] i_pull_down,
   input wire [15:0] i_ext_val,
   input wire [15:0] i_ext_en,
   output logic [15:0] o_pin
);
   logic [15:0] last_reg;
   always @(posedge i_ref_clk) begin
      last_reg <= o_pin;
   end
   always @* begin
      for (int k = 0; k < 16; k++) begin
         if (!i_drive_oe_n[k])
            o_pin[k] = i_drive[k];
         else if (i_ext_en[k])
            o_pin[k] = i_ext_val[k];
         else if (i_pull_up[k] || i_pull_down[k])
            o_pin[k] = i_pull_up[k];
         else
            o_pin[k] = ~last_reg[k];
      end
   end
endmodule

// ==== verif/gpcn_port_test.sv ====
`timescale 1ns/1ps
`include "gpcn_defs.vh"
// ******************************************
// Self-checking bench of the port slice.
// ******************************************
module gpcn_port_test;
   logic clk, rstn, wr_en, rd_en, rd_seen, irq, wake;
   logic [2:0] wr_sel, rd_sel;
   logic [1:0] wr_op, rd_op;
   logic [63:0] remap_sel;
   logic [7:0] remap_out, remap_oe;
   logic [15:0] wr_data, fix_en, fix_out, fix_oe, ext_val, ext_en, pin_in, rd_data, pin_out;
   logic [15:0] oe_n, pu, pd, aen, periph_in, fixed_in, cstat, m, e, d;
   logic [15:0] exp_q[$];
   int errors, num_checks, rnd;
   gpcn_port dut_u (.i_ref_clk(clk), .i_resetn(rstn), .i_wr_en(wr_en), .i_wr_sel(wr_sel),
      .i_wr_op(wr_op), .i_wr_data(wr_data), .i_rd_en(rd_en), .i_rd_sel(rd_sel),
      .i_rd_op(rd_op), .i_pin_in(pin_in), .i_remap_sel(remap_sel), .i_remap_out(remap_out),
      .i_remap_oe(remap_oe), .i_fixed_en(fix_en), .i_fixed_out(fix_out), .i_fixed_oe(fix_oe),
      .o_rd_data(rd_data), .o_pin_out(pin_out), .o_pin_oe_n(oe_n), .o_pull_up(pu),
      .o_pull_down(pd), .o_analog_en(aen), .o_periph_in(periph_in), .o_fixed_in(fixed_in),
      .o_change_status(cstat), .o_change_irq(irq), .o_wake_req(wake));
   gpcn_pins_model pins_u (.i_ref_clk(clk), .i_drive(pin_out), .i_drive_oe_n(oe_n),
      .i_pull_up(pu), .i_pull_down(pd), .i_ext_val(ext_val), .i_ext_en(ext_en), .o_pin(pin_in));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wr(input logic [2:0] s, input logic [1:0] o, input logic [15:0] v);
      @(negedge clk);
      wr_en = 1'b1;
      wr_sel = s;
      wr_op = o;
      wr_data = v;
      @(negedge clk);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [2:0] s, input logic [1:0] o, input logic [15:0] v);
      @(negedge clk);
      rd_en = 1'b1;
      rd_sel = s;
      rd_op = o;
      exp_q.push_back(v);
      @(negedge clk);
      rd_en = 1'b0;
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk) begin
      if (rd_seen === 1'b1 && exp_q.size() > 0)
         cmp(rd_data, exp_q.pop_front());
      rd_seen <= rd_en;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      errors++;
      end_sim();
   end
   initial begin
      {rstn, wr_en, rd_en, wr_sel, rd_sel, wr_op, rd_op, wr_data} = '0;
      {remap_sel, remap_out, remap_oe, fix_en, fix_out, fix_oe, ext_val} = '0;
      ext_en = 16'hffff;
      errors = 0;
      num_checks = 0;
      rnd = $urandom(32'h80a7);
      tick(16);
      rstn = 1'b1;
      cmp(aen, 16'hffff);
      cmp(oe_n, 16'hffff);
      rd(3'h0, 2'h0, 16'hffff);
      rd(3'h1, 2'h0, 16'hffff);
      for (int s = 0; s < 7; s++) begin
         m = (s == 4) ? `GPCN_CN_CAPABLE : 16'hffff;
         e = 16'($urandom);
         wr(s[2:0], 2'h0, e);
         for (int o = 1; o < 4; o++) begin
            d = 16'($urandom);
            wr(s[2:0], o[1:0], d);
            e = (o == 1) ? (e | d) : (o == 2) ? (e & ~d) : (e ^ d);
            rd(s[2:0], o[1:0], 16'h0000);
         end
         rd(s[2:0], 2'h0, e & m);
         if (s == 5)
            cmp(pu, e);
         if (s == 6)
            cmp(pd, e);
      end
      wr(3'h7, 2'h0, 16'h5a5a);
      rd(3'h2, 2'h0, 16'h5a5a);
      for (int s = 3; s < 7; s++)
         wr(s[2:0], 2'h0, 16'h0000);
      wr(3'h1, 2'h0, 16'hffff);
      wr(3'h0, 2'h0, 16'h00ff);
      ext_val = 16'($urandom) & 16'hfffe;
      tick(4);
      rd(3'h7, 2'h0, ext_val & 16'hff00);
      cmp(periph_in, ext_val & 16'hff00);
      wr(3'h0, 2'h0, 16'h0000);
      wr(3'h4, 2'h0, 16'hffff);
      tick(4);
      rd(3'h7, 2'h0, ext_val);
      tick(3);
      cmp(cstat, 16'h0000);
      ext_val = ext_val ^ 16'h07c1;
      tick(5);
      cmp(cstat, 16'h0041);
      cmp({15'h0, irq}, 16'h0001);
      cmp({15'h0, wake}, 16'h0001);
      rd(3'h7, 2'h0, ext_val);
      tick(3);
      cmp(cstat, 16'h0000);
      cmp({15'h0, wake}, 16'h0000);
      wr(3'h4, 2'h0, 16'h0002);
      ext_val = ext_val ^ 16'h0003;
      tick(5);
      cmp(cstat, 16'h0002);
      cmp({15'h0, irq}, 16'h0001);
      rd(3'h7, 2'h0, ext_val);
      wr(3'h4, 2'h0, 16'h0000);
      wr(3'h1, 2'h0, 16'h0000);
      wr(3'h2, 2'h0, 16'h0002);
      remap_out = 8'h01;
      remap_oe = 8'h01;
      fix_en = 16'h0005;
      fix_out = 16'h0004;
      fix_oe = 16'hffff;
      tick(2);
      cmp(pin_out & 16'h0005, 16'h0004);
      remap_sel[3:0] = 4'h1;
      tick(4);
      cmp(pin_out & 16'h0007, 16'h0007);
      cmp(fixed_in & 16'h0004, 16'h0004);
      wr(3'h0, 2'h0, 16'h0001);
      tick(2);
      cmp(pin_out & 16'h0001, 16'h0000);
      cmp(oe_n & 16'h0001, 16'h0000);
      wr(3'h3, 2'h0, 16'h0002);
      tick(2);
      cmp(oe_n & 16'h0002, 16'h0002);
      cmp(pin_out & 16'h0002, 16'h0000);
      wr(3'h2, 2'h0, 16'h0000);
      tick(2);
      cmp(oe_n & 16'h0002, 16'h0000);
      tick(4);
      end_sim();
   end
endmodule
